//--- logic/sdc_pkg.sv
// Shared constants and types for the synchronous DRAM command-timing core.
// Assumes all memory pins are launched by the controller on the same clock
// that runs this core, so they need no synchroniser.

package sdc_pkg;

  localparam int SDC_BANKS = 4;
  localparam int SDC_BA_W = 2;
  localparam int SDC_ADDR_W = 12;
  localparam int SDC_COL_W = 8;
  localparam int SDC_DQ_W = 16;
  localparam int SDC_LANES = 2;

  // Mode word field positions, then the precharge all-banks address bit
  localparam int SDC_MR_BL_LSB = 0;
  localparam int SDC_MR_BT_BIT = 3;
  localparam int SDC_MR_CL_LSB = 4;
  localparam int SDC_MR_WB_BIT = 9;
  localparam int SDC_AP_BIT = 10;

  // Latency three, burst of one, sequential, burst writes
  localparam logic [SDC_ADDR_W-1:0] SDC_MR_RESET = 12'h030;
  localparam logic [2:0] SDC_CL_THREE = 3'h3;
  localparam logic [2:0] SDC_BL_FULL = 3'h7;

  typedef enum logic [2:0] {
    SDC_OP_LOAD = 3'b000,
    SDC_OP_REFRESH = 3'b001,
    SDC_OP_PRECHARGE = 3'b010,
    SDC_OP_ACTIVATE = 3'b011,
    SDC_OP_WRITE = 3'b100,
    SDC_OP_READ = 3'b101,
    SDC_OP_STOP = 3'b110,
    SDC_OP_NOP = 3'b111
  } sdc_op_t;

  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [SDC_BA_W-1:0] ba;
    logic [SDC_ADDR_W-1:0] addr;
  } sdc_cmd_t;

endpackage

//--- logic/sdc_core.sv
// Device-side logic of a four-bank synchronous DRAM: command decode, bank
// rows, mode word, bursts, clock-enable suspend and byte-mask lanes.
// Assumes the controller obeys all spacing limits; this core does not check them.
// Refresh, self refresh and power-down change nothing here beyond needing cke.
// Auto precharge is ignored: the open row of a bank stays valid until replaced.
`timescale 1ns/1ps
`default_nettype none

module sdc_core #(
  parameter int ROW_W = 12
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Command pins
  input wire logic cke_in,
  input wire sdc_pkg::sdc_cmd_t cmd_in,
  input wire logic [sdc_pkg::SDC_LANES-1:0] dqm_in,
  // Data pins, split three ways
  input wire logic [sdc_pkg::SDC_DQ_W-1:0] dq_in,
  output logic [sdc_pkg::SDC_DQ_W-1:0] dq_out,
  output logic [sdc_pkg::SDC_LANES-1:0] dq_oe_b_out
);
  import sdc_pkg::*;

  localparam int IDX_W = SDC_BA_W + ROW_W + SDC_COL_W;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [SDC_COL_W-1:0] burst_mask(input logic [2:0] code);
    logic [SDC_COL_W-1:0] m;
    m = 8'h00;
    unique case (code)
      3'h1: m = 8'h01;
      3'h2: m = 8'h03;
      3'h3: m = 8'h07;
      3'h7: m = 8'hFF;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [SDC_DQ_W-1:0] mem [0:(1<<IDX_W)-1];
  logic cke_q;
  logic [SDC_ADDR_W-1:0] mode_q;
  logic [SDC_ADDR_W-1:0] row_q [SDC_BANKS];
  logic burst_q;
  logic wr_q;
  logic [SDC_BA_W-1:0] bank_q;
  logic [SDC_COL_W-1:0] col_q;
  logic [SDC_COL_W-1:0] cnt_q;
  logic st0_v_q;
  logic st1_v_q;
  logic [SDC_DQ_W-1:0] st0_q;
  logic [SDC_DQ_W-1:0] st1_q;
  logic [SDC_DQ_W-1:0] out_q;
  logic [SDC_LANES-1:0] dqm_q;
  logic [SDC_LANES-1:0] oe_b_q;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Clock-enable sampled on one edge governs the next edge only
  wire logic live = cke_q;
  wire logic cmd_sel = live && !cmd_in.cs_b;
  wire sdc_op_t op = sdc_op_t'({cmd_in.ras_b, cmd_in.cas_b, cmd_in.we_b});
  wire logic is_act = cmd_sel && (op == SDC_OP_ACTIVATE);
  wire logic is_rd = cmd_sel && (op == SDC_OP_READ);
  wire logic is_wr = cmd_sel && (op == SDC_OP_WRITE);
  wire logic is_pre = cmd_sel && (op == SDC_OP_PRECHARGE);
  wire logic is_stop = cmd_sel && (op == SDC_OP_STOP);
  wire logic is_load = cmd_sel && (op == SDC_OP_LOAD);
  wire logic all_banks = cmd_in.addr[SDC_AP_BIT];

  wire logic [2:0] bl_code = mode_q[SDC_MR_BL_LSB +: 3];
  wire logic interleave = mode_q[SDC_MR_BT_BIT];
  wire logic cl_three = (mode_q[SDC_MR_CL_LSB +: 3] == SDC_CL_THREE);
  wire logic single_wr = mode_q[SDC_MR_WB_BIT];

  // ----------------------------------------------------------------
  // Burst address generation
  // ----------------------------------------------------------------
  // A new column command simply replaces any running burst
  wire logic start_rw = is_rd || is_wr;
  // Precharge of the burst's bank ends fetching; words in flight still leave
  wire logic halt = is_stop || (is_pre && (all_banks || cmd_in.ba == bank_q));
  wire logic acc_wr = start_rw ? is_wr : wr_q;
  wire logic [SDC_BA_W-1:0] acc_bank = start_rw ? cmd_in.ba : bank_q;
  wire logic [SDC_COL_W-1:0] acc_start = start_rw ? cmd_in.addr[SDC_COL_W-1:0] : col_q;
  wire logic [SDC_COL_W-1:0] acc_cnt = start_rw ? 8'h00 : cnt_q;
  wire logic acc_live = start_rw || (burst_q && live && !halt);
  wire logic [SDC_COL_W-1:0] acc_mask = (acc_wr && single_wr) ? 8'h00 : burst_mask(bl_code);
  wire logic full_page = (bl_code == SDC_BL_FULL) && !(acc_wr && single_wr);
  wire logic acc_last = !full_page && (acc_cnt == acc_mask);
  wire logic [SDC_COL_W-1:0] acc_off = interleave ? (acc_start ^ acc_cnt)
                                                  : SDC_COL_W'(acc_start + acc_cnt);
  wire logic [SDC_COL_W-1:0] acc_col = (acc_start & ~acc_mask) | (acc_off & acc_mask);
  wire logic [IDX_W-1:0] acc_idx = {acc_bank, row_q[acc_bank][ROW_W-1:0], acc_col};
  wire logic rd_go = acc_live && !acc_wr;
  wire logic wr_go = acc_live && acc_wr;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_q <= SDC_MR_RESET;
    end else if (is_load) begin
      mode_q <= cmd_in.addr;
    end
  end

  // Row held per bank; auto precharge needs no state since the row stays valid
  // for the remainder of the burst
  for (genvar b = 0; b < SDC_BANKS; b++) begin : g_bank
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        row_q[b] <= '0;
      end else if (is_act && cmd_in.ba == SDC_BA_W'(b)) begin
        row_q[b] <= cmd_in.addr;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      burst_q <= 1'b0;
      wr_q <= 1'b0;
      bank_q <= '0;
      col_q <= '0;
      cnt_q <= '0;
    end else if (live) begin
      burst_q <= acc_live && !acc_last;
      wr_q <= acc_wr;
      bank_q <= acc_bank;
      col_q <= acc_start;
      cnt_q <= SDC_COL_W'(acc_cnt + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Word zero is taken with the command; a set mask bit blocks its lane.
  // A single process owns the array so the two lanes never race for it.
  wire logic [SDC_LANES-1:0] lane_we;
  for (genvar l = 0; l < SDC_LANES; l++) begin : g_wlane
    assign lane_we[l] = wr_go && !dqm_in[l];
  end

  always_ff @(posedge mclk_in) begin
    for (int l = 0; l < SDC_LANES; l++) begin
      if (lane_we[l]) begin
        mem[acc_idx][l*8 +: 8] <= dq_in[l*8 +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Fetch on the access edge, then one or two more stages to the pins.
  // The whole pipe freezes while the clock is suspended.
  // Latency two taps the first stage, latency three the second.
  wire logic sel_v = cl_three ? st1_v_q : st0_v_q;
  wire logic [SDC_DQ_W-1:0] sel_d = cl_three ? st1_q : st0_q;

  always_ff @(posedge mclk_in) begin
    if (live) begin
      st0_q <= mem[acc_idx];
      st1_q <= st0_q;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st0_v_q <= 1'b0;
      st1_v_q <= 1'b0;
    end else if (live) begin
      st0_v_q <= rd_go;
      st1_v_q <= st0_v_q;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Pins come only from flops so decode glitches never reach the bus;
  // this output flop is the last of the latency stages.
  // Mask seen on one edge gates the word launched on the next
  wire logic [SDC_LANES-1:0] lane_oe_b = ~({SDC_LANES{sel_v}} & ~dqm_q);

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_q <= '0;
      dqm_q <= '1;
      oe_b_q <= '1;
    end else if (live) begin
      out_q <= sel_d;
      dqm_q <= dqm_in;
      oe_b_q <= lane_oe_b;
    end
  end

  assign dq_out = out_q;
  assign dq_oe_b_out = oe_b_q;

endmodule

`default_nettype wire

//--- test/sdc_core_monitor.sv
// Checker for the core's read pipeline, mask lanes and clock enable.
// Assumes only the core's ports; pipeline checks hold in the reset mode.
`timescale 1ns/1ps
`default_nettype none
module sdc_core_monitor (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Pins
  input wire logic cke_in,
  input wire sdc_pkg::sdc_cmd_t cmd_in,
  input wire logic [1:0] dqm_in,
  input wire logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe_b_out
);
  import sdc_pkg::*;
  logic en_q;
  logic dflt_q;
  wire logic [2:0] op = {cmd_in.ras_b, cmd_in.cas_b, cmd_in.we_b};
  wire logic taken = en_q && !cmd_in.cs_b;
  wire logic rd = taken && op == SDC_OP_READ && dflt_q;
  wire logic clean = cke_in && dqm_in == 2'h0;
  // A mode load leaves the reset mode, so pipeline checks stand down
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_q <= 1'b0;
      dflt_q <= 1'b1;
    end else begin
      en_q <= cke_in;
      if (taken && op == SDC_OP_LOAD) begin
        dflt_q <= 1'b0;
      end
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_rd;
    rd && cke_in ##1 clean ##1 cke_in;
  endsequence
  a_read_three: assert property (s_rd |=> dq_oe_b_out == 2'h0)
    else $error("read word late");
  a_back_to_back: assert property (rd && cke_in ##1 rd && clean ##1 clean
    |=> dq_oe_b_out == 2'h0 [*2]) else $error("second read lost");
  a_idle_off: assert property (dflt_q && en_q && cke_in && !rd ##1 cke_in && dflt_q
    ##1 cke_in |=> dq_oe_b_out == 2'h3) else $error("driving without read");
  a_freeze_hold: assert property (!cke_in |-> ##2 $stable(dq_out) && $stable(dq_oe_b_out))
    else $error("outputs moved while suspended");
  a_resume_read: assert property (rd && cke_in ##1 !cke_in && dqm_in == 2'h0 ##1 clean
    ##1 clean |=> dq_oe_b_out == 2'h0) else $error("resume slip");
  a_mask_lane0: assert property (rd && cke_in ##1 cke_in && dqm_in[0] ##1 cke_in
    |=> dq_oe_b_out[0]) else $error("lane 0 not masked");
  a_mask_lane1: assert property (rd && cke_in ##1 cke_in && dqm_in[1] ##1 cke_in
    |=> dq_oe_b_out[1]) else $error("lane 1 not masked");
  a_lanes_agree: assert property (en_q && clean |-> ##2 dq_oe_b_out[0] == dq_oe_b_out[1])
    else $error("lanes split");
endmodule
`default_nettype wire

//--- test/sdc_ctl_model.sv
// Memory controller model: one command per call, bank 1 only.
// Assumes the caller spaces commands in whole cycles, rounded up.
`timescale 1ns/1ps
`default_nettype none
module sdc_ctl_model (
  input wire logic mclk_in,
  output logic cke_out,
  output sdc_pkg::sdc_cmd_t cmd_out,
  output logic [1:0] dqm_out,
  output logic [15:0] dq_drv_out
);
  import sdc_pkg::*;
  initial begin
    cke_out = 1'b1;
    cmd_out = {1'b1, SDC_OP_NOP, 14'h0000};
    dqm_out = 2'h3;
    dq_drv_out = 16'h0000;
  end
  // Held a whole cycle
  // refresh and auto precharge are never issued
  task automatic cmd(input sdc_op_t op, input logic [11:0] a, input logic [15:0] d = 16'h0,
                     input logic [1:0] m = 2'h0, input logic ck = 1'b1);
    @(posedge mclk_in);
    #1;
    cmd_out = {op == SDC_OP_NOP, op, 2'h1, a};
    dqm_out = m;
    cke_out = ck;
    // Idle data lines toggle so a stale word never passes
    dq_drv_out = (op == SDC_OP_WRITE) ? d : ~dq_drv_out;
  endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the DRAM core with a controller model.
// Assumes the core's reset mode: latency three, single-word bursts.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %h want %h", $time, (a), (e)); end end
module testbench;
  import sdc_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cke;
  sdc_cmd_t cmd;
  logic [1:0] dqm;
  logic [15:0] dq_drv;
  logic [15:0] dq_rd;
  logic [1:0] oe_b;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  initial begin
    forever #5 mclk = ~mclk;
  end
  sdc_ctl_model u_ctl (.mclk_in(mclk), .cke_out(cke), .cmd_out(cmd), .dqm_out(dqm),
    .dq_drv_out(dq_drv));
  sdc_core #(.ROW_W(2)) DUT (.mclk_in(mclk), .rst_b_in(rst_b), .cke_in(cke), .cmd_in(cmd),
    .dqm_in(dqm), .dq_in(dq_drv), .dq_out(dq_rd), .dq_oe_b_out(oe_b));
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Ceiling far above the seventy or so cycles the scenarios need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end
  task nop(input logic [1:0] m = 2'h0, input logic ck = 1'b1);
    u_ctl.cmd(SDC_OP_NOP, 12'h000, 16'h0, m, ck);
  endtask
  // Lanes that are off are not compared for data
  task chk(input logic [15:0] w, input logic [1:0] oe);
    `CHK(oe_b, oe)
    `CHK(dq_rd | {{8{oe[1]}}, {8{oe[0]}}}, w | {{8{oe[1]}}, {8{oe[0]}}})
  endtask
  task reset;
    @(posedge mclk);
    #1 rst_b = 1'b0;
    repeat (6) @(posedge mclk);
    #1 rst_b = 1'b1;
  endtask
  task t_fill;
    u_ctl.cmd(SDC_OP_ACTIVATE, 12'h000);
    nop();
    nop();
    u_ctl.cmd(SDC_OP_WRITE, 12'h006, 16'hFFFF);
    u_ctl.cmd(SDC_OP_WRITE, 12'h005, 16'hA5C3);
    u_ctl.cmd(SDC_OP_WRITE, 12'h006, 16'h1234, 2'h2);
    u_ctl.cmd(SDC_OP_WRITE, 12'h004, 16'h0F0F);
    nop();
  endtask
  task t_read_pair;
    u_ctl.cmd(SDC_OP_READ, 12'h005);
    u_ctl.cmd(SDC_OP_READ, 12'h006);
    nop();
    nop();
    chk(16'hA5C3, 2'h0);
    nop();
    chk(16'hFF34, 2'h0);
    nop();
    chk(16'h0000, 2'h3);
  endtask
  task t_mask;
    u_ctl.cmd(SDC_OP_READ, 12'h005);
    nop(2'h1);
    nop();
    nop();
    chk(16'hA5C3, 2'h1);
    u_ctl.cmd(SDC_OP_READ, 12'h006);
    nop(2'h2);
    nop();
    nop();
    chk(16'hFF34, 2'h2);
  endtask
  task t_suspend;
    u_ctl.cmd(SDC_OP_READ, 12'h005);
    nop(2'h0, 1'b0);
    nop();
    nop();
    chk(16'h0000, 2'h3);
    nop();
    chk(16'hA5C3, 2'h0);
  endtask
  // Latency two, four-word bursts, then a precharge cuts the burst
  task t_cut;
    u_ctl.cmd(SDC_OP_PRECHARGE, 12'h400);
    nop();
    nop();
    u_ctl.cmd(SDC_OP_LOAD, 12'h022);
    nop();
    nop();
    u_ctl.cmd(SDC_OP_ACTIVATE, 12'h000);
    nop();
    nop();
    u_ctl.cmd(SDC_OP_READ, 12'h004);
    u_ctl.cmd(SDC_OP_PRECHARGE, 12'h000);
    nop();
    chk(16'h0F0F, 2'h0);
    nop();
    chk(16'h0000, 2'h3);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_b = 1'b1;
    t_fill();
    t_read_pair();
    t_mask();
    t_suspend();
    t_cut();
    reset();
    t_fill();
    t_read_pair();
    conclude();
  end
endmodule
bind sdc_core sdc_core_monitor u_mon (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .cke_in(cke_in),
  .cmd_in(cmd_in), .dqm_in(dqm_in), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_b_out(dq_oe_b_out));
`default_nettype wire
